//--- rtl/host_cmd_status_regs.vh
// register codes, field positions and timing counts of the command/status block
`ifndef HOST_CMD_STATUS_REGS_VH
`define HOST_CMD_STATUS_REGS_VH

// command codes on the processor command port
`define CMD_STATUS_READ      8'h02
`define CMD_STATUS_WRITE     8'h82
`define INT_STATUS_READ      8'h03
`define INT_STATUS_WRITE     8'h83

// command/status field positions
`define RESET_REQ_BIT        0
`define TALLY_LSB            16
`define TALLY_MSB            17
`define TALLY_W              2

// interrupt status field positions
`define OVERRUN_FLAG_BIT     0

// reset values
`define TALLY_RESET          2'h0
`define RESET_REQ_RESET      1'h0
`define OVERRUN_FLAG_RESET   1'h0
`define RD_DATA_RESET        32'h0000_0000
`define RD_VALID_RESET       1'h0
`define SUSPEND_RESET        1'h0
`define CORE_RESET_OFF       1'h0
`define BUSY_RESET           1'h0
`define BUS_REQ_RESET        1'h0
`define CNT_RESET            8'h00

// timing
`define CLK_PERIOD_NS        20
`define SOFT_RESET_NS        1000
`define SOFT_RESET_MAX_NS    10000
`define SOFT_RESET_CYCLES    ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CNT_W          8

`endif

//--- rtl/host_command_status_reset.v
// command/status register: overrun tally and core soft reset sequencer
//
// Operation
// - each schedule overrun detected outside a soft reset adds one to the tally in bits 17..16.
// - tally is zero after reset and wraps from three to zero.
// - tally counts every overrun even while the overrun flag is already set.
// - a soft reset request forces the core into suspend state.
// - soft reset returns operational registers to reset values, preserved ones excepted.
// - no host bus accesses while the soft reset is running.
// - the device clears the request bit itself when the reset is done.
// - whole soft reset finishes within ten microseconds of the request.
// - soft reset never resets the root hub logic.
// - no reset signalling is driven on downstream ports after a soft reset.
// - command/status is read with code 02h and written with code 82h.
// - overrun flag in interrupt status is set by the same overrun event.
`timescale 1ns/100ps
`include "host_cmd_status_regs.vh"

module host_command_status_reset (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire [31:0] cmd_wdata,
  output reg  [31:0] rd_data,
  output reg         rd_valid,
  input  wire        overrun_event,
  input  wire        core_bus_req,
  output reg         host_bus_req,
  input  wire        suspend_leave,
  output reg         suspend_state,
  output reg         core_reset,
  output reg         reset_busy,
  output reg         overrun_flag,
  output reg  [1:0]  overrun_tally_field,
  output reg         soft_reset_request
);

  localparam [1:0] st_idle   = 2'h0;
  localparam [1:0] st_active = 2'h1;
  localparam [1:0] st_done   = 2'h2;

  // count kept as a whole number of cycles, trimmed to the counter width
  localparam integer            reset_cycles_full = `SOFT_RESET_CYCLES;
  localparam [`RESET_CNT_W-1:0] reset_cycles      = reset_cycles_full[`RESET_CNT_W-1:0];
  localparam [`RESET_CNT_W-1:0] cnt_zero     = 8'h00;
  localparam [`RESET_CNT_W-1:0] cnt_one      = 8'h01;

  reg  [1:0]              rst_state;
  reg  [1:0]              next_rst_state;
  reg  [`RESET_CNT_W-1:0] rst_cnt;
  reg  [`RESET_CNT_W-1:0] next_rst_cnt;
  reg  [1:0]              next_tally;
  reg                     next_overrun_flag;
  reg                     next_request;
  reg                     next_suspend;
  reg  [31:0]             next_rd_data;
  reg                     next_rd_valid;
  reg                     next_core_reset;
  reg                     next_reset_busy;
  reg                     next_host_bus_req;

  wire                    wr_cmd_status;
  wire                    rd_cmd_status;
  wire                    wr_int_status;
  wire                    rd_int_status;
  wire                    reset_start;
  wire                    in_reset;
  wire                    cnt_last;
  wire                    reset_done;

  function cmd_hit;
    input       valid;
    input [7:0] code;
    input [7:0] want;
    begin
      cmd_hit = valid & (code == want);
    end
  endfunction

  // cmd/status read word; reserved bits stay zero
  function [31:0] status_word;
    input [1:0] tally;
    input       request;
    begin
      status_word                        = `RD_DATA_RESET;
      status_word[`TALLY_MSB:`TALLY_LSB] = tally;
      status_word[`RESET_REQ_BIT]        = request;
    end
  endfunction

  assign wr_cmd_status = cmd_hit(cmd_valid, cmd_code, `CMD_STATUS_WRITE);
  assign rd_cmd_status = cmd_hit(cmd_valid, cmd_code, `CMD_STATUS_READ);
  assign wr_int_status = cmd_hit(cmd_valid, cmd_code, `INT_STATUS_WRITE);
  assign rd_int_status = cmd_hit(cmd_valid, cmd_code, `INT_STATUS_READ);

  // only a one starts a reset; a second one while busy is absorbed
  assign reset_start = wr_cmd_status & cmd_wdata[`RESET_REQ_BIT] & (rst_state == st_idle);
  assign in_reset    = (rst_state != st_idle);
  // countdown ends at one, so the active phase lasts exactly the count
  assign cnt_last    = (rst_cnt <= cnt_one);
  assign reset_done  = (rst_state == st_done);

  // soft reset sequencer
  always @* begin
    next_rst_state = rst_state;
    next_rst_cnt   = rst_cnt;
    case (rst_state)
      st_idle: begin
        // only an idle sequencer starts a new sequence
        if (reset_start) begin
          next_rst_state = st_active;
          next_rst_cnt   = reset_cycles;
        end
      end
      st_active: begin
        // fixed length keeps the whole sequence well under the limit
        if (cnt_last) begin
          next_rst_state = st_done;
          next_rst_cnt   = cnt_zero;
        end else begin
          next_rst_cnt = rst_cnt - cnt_one;
        end
      end
      st_done: begin
        // one spare cycle lets the request bit and busy fall together
        next_rst_state = st_idle;
      end
      default: begin
        next_rst_state = st_idle;
        next_rst_cnt   = cnt_zero;
      end
    endcase
  end

  // request bit: set by software, cleared by the sequencer only
  always @* begin
    next_request = soft_reset_request;
    // a zero write never reaches the bit, so software cannot cancel
    if (reset_start) begin
      next_request = 1'h1;
    end else if (reset_done) begin
      next_request = 1'h0;
    end
  end

  // overrun tally
  always @* begin
    next_tally = overrun_tally_field;
    if (in_reset | reset_start) begin
      next_tally = `TALLY_RESET;
    end else if (overrun_event) begin
      // plain two-bit add, no saturation, flag state not consulted
      next_tally = overrun_tally_field + 2'h1;
    end
  end

  // overrun flag: a set in the same cycle as a clear wins
  always @* begin
    next_overrun_flag = overrun_flag;
    if (in_reset | reset_start) begin
      next_overrun_flag = `OVERRUN_FLAG_RESET;
    end else if (overrun_event) begin
      next_overrun_flag = 1'h1;
    end else if (wr_int_status & cmd_wdata[`OVERRUN_FLAG_BIT]) begin
      next_overrun_flag = 1'h0;
    end
  end

  // suspend state: entered on any reset start, left on suspend_leave outside a reset
  always @* begin
    next_suspend = suspend_state;
    if (reset_start | in_reset) begin
      next_suspend = 1'h1;
    end else if (suspend_leave) begin
      next_suspend = 1'h0;
    end
  end

  // read path: unknown codes with bit 7 clear still answer, with zero data
  always @* begin
    next_rd_data  = `RD_DATA_RESET;
    next_rd_valid = 1'h0;
    if (cmd_valid & ~cmd_code[7]) begin
      next_rd_valid = 1'h1;
      if (rd_cmd_status) begin
        next_rd_data = status_word(overrun_tally_field, soft_reset_request);
      end else if (rd_int_status) begin
        next_rd_data[`OVERRUN_FLAG_BIT] = overrun_flag;
      end
    end
  end

  // reset controls, one cycle ahead of their flops
  always @* begin
    // core registers only; the root hub and its port signalling stay untouched
    next_core_reset = (next_rst_state == st_active);
    next_reset_busy = (next_rst_state != st_idle);
  end

  // bus requests are dropped for the whole sequence
  always @* begin
    // only an idle sequencer lets a core request through
    next_host_bus_req = core_bus_req & (next_rst_state == st_idle) & ~reset_start;
  end

  // one flop per process, so every output leaves a bare register
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_state <= st_idle;
    end else begin
      rst_state <= next_rst_state;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt <= `CNT_RESET;
    end else begin
      rst_cnt <= next_rst_cnt;
    end
  end

  // software visible fields
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_reset_request <= `RESET_REQ_RESET;
    end else begin
      soft_reset_request <= next_request;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      overrun_tally_field <= `TALLY_RESET;
    end else begin
      overrun_tally_field <= next_tally;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      overrun_flag <= `OVERRUN_FLAG_RESET;
    end else begin
      overrun_flag <= next_overrun_flag;
    end
  end

  // suspend and reset controls
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      suspend_state <= `SUSPEND_RESET;
    end else begin
      suspend_state <= next_suspend;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      core_reset <= `CORE_RESET_OFF;
    end else begin
      core_reset <= next_core_reset;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_busy <= `BUSY_RESET;
    end else begin
      reset_busy <= next_reset_busy;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      host_bus_req <= `BUS_REQ_RESET;
    end else begin
      host_bus_req <= next_host_bus_req;
    end
  end

  // read answer, one cycle after the command
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= `RD_DATA_RESET;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= `RD_VALID_RESET;
    end else begin
      rd_valid <= next_rd_valid;
    end
  end

endmodule // host_command_status_reset

//--- verification/host_command_status_reset_monitor.sv
// port checker of the command/status block
`timescale 1ns/100ps
module host_command_status_reset_monitor (
  input wire        mclk,
  input wire        sys_rst,
  input wire        cmd_valid,
  input wire [7:0]  cmd_code,
  input wire [31:0] cmd_wdata,
  input wire [31:0] rd_data,
  input wire        rd_valid,
  input wire        overrun_event,
  input wire        host_bus_req,
  input wire        suspend_state,
  input wire        core_reset,
  input wire        reset_busy,
  input wire        overrun_flag,
  input wire [1:0]  overrun_tally_field,
  input wire        soft_reset_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire start = cmd_valid && cmd_code == 8'h82 && cmd_wdata[0];
  wire quiet = !reset_busy && !soft_reset_request && !start;
  chk_read_answer: assert property (
    cmd_valid && cmd_code == 8'h02 |=> rd_valid && rd_data[31:18] == 14'h0 && rd_data[15:1] == 15'h0)
    else $error("bad read answer");
  chk_tally_step: assert property (
    overrun_event && quiet |=> overrun_tally_field == $past(overrun_tally_field) + 2'h1)
    else $error("tally did not step");
  chk_flag_set: assert property (
    overrun_event && quiet |=> overrun_flag) else $error("flag not set");
  chk_reset_entry: assert property (
    start && quiet == 1'b0 && !reset_busy && !soft_reset_request
    |=> soft_reset_request && suspend_state && core_reset && overrun_tally_field == 2'h0 && !host_bus_req)
    else $error("soft reset entry wrong");
  chk_no_bus: assert property (
    reset_busy || core_reset |-> !host_bus_req) else $error("bus access during reset");
  chk_reset_bound: assert property (
    $rose(soft_reset_request) |-> ##[1:500] !soft_reset_request) else $error("reset too long");
  chk_zero_write: assert property (
    cmd_valid && cmd_code == 8'h82 && !cmd_wdata[0] && !soft_reset_request |=> !soft_reset_request)
    else $error("zero write started reset");
  chk_suspend_held: assert property (
    soft_reset_request |-> suspend_state) else $error("not in suspend");
  chk_busy_tracks: assert property (
    reset_busy == soft_reset_request) else $error("busy and request bit differ");
endmodule // host_command_status_reset_monitor
bind host_command_status_reset host_command_status_reset_monitor mon_i (.mclk, .sys_rst, .cmd_valid,
  .cmd_code, .cmd_wdata, .rd_data, .rd_valid, .overrun_event, .host_bus_req, .suspend_state,
  .core_reset, .reset_busy, .overrun_flag, .overrun_tally_field, .soft_reset_request);

//--- verification/host_cpu_model.sv
// host processor model issuing commands
`timescale 1ns/100ps
module host_cpu_model (
  input  wire        mclk,
  output reg         cmd_valid,
  output reg  [7:0]  cmd_code,
  output reg  [31:0] cmd_wdata,
  input  wire [31:0] rd_data,
  input  wire        rd_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h0;
  end
  // one-cycle strobe; idle lines show inverted garbage, not the last value
  task cmd(input [7:0] c, input [31:0] d, output [31:0] q);
    begin
      @(posedge mclk);
      #1 cmd_valid = 1'b1;
      cmd_code = c;
      cmd_wdata = d;
      @(posedge mclk);
      #1 cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_wdata = ~d;
      // the answer stands in the cycle after the taking edge; read it settled
      q = c[7] ? 32'h0 : ((rd_valid === 1'b1) ? rd_data : 32'hdead_0000);
    end
  endtask
endmodule // host_cpu_model

//--- verification/testbench.sv
// self-checking bench of the command/status block
`timescale 1ns/100ps
module testbench;
  reg         mclk, sys_rst, overrun_event, core_bus_req, suspend_leave;
  wire        cmd_valid, rd_valid, host_bus_req, suspend_state, core_reset, reset_busy, overrun_flag;
  wire        soft_reset_request;
  wire [7:0]  cmd_code;
  wire [31:0] cmd_wdata, rd_data;
  wire [1:0]  overrun_tally_field;
  reg  [31:0] q;
  integer     fail_count = 0, num_checks = 0, cyc = 0, i;
  time        t0;
  host_command_status_reset host_command_status_reset_i (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .overrun_event(overrun_event), .core_bus_req(core_bus_req),
    .host_bus_req(host_bus_req), .suspend_leave(suspend_leave), .suspend_state(suspend_state),
    .core_reset(core_reset), .reset_busy(reset_busy), .overrun_flag(overrun_flag),
    .overrun_tally_field(overrun_tally_field), .soft_reset_request(soft_reset_request));
  host_cpu_model host_cpu_model_i (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task check(input string n, input [31:0] s, input [31:0] e);
    begin
      num_checks++;
      if (s !== e) begin
        fail_count++;
        $display("mismatch %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task rd(input [7:0] c, input [31:0] e, input string n);
    begin
      host_cpu_model_i.cmd(c, 32'h0, q);
      check(n, q, e);
    end
  endtask
  task pulse;
    begin
      @(posedge mclk);
      #1 overrun_event = 1'b1;
      @(posedge mclk);
      #1 overrun_event = 1'b0;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ceiling well above the hundred or so cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results;
    end
  end
  initial begin
    sys_rst = 1'b1;
    overrun_event = 1'b0;
    core_bus_req = 1'b0;
    suspend_leave = 1'b0;
    repeat (4) @(posedge mclk);
    #1 sys_rst = 1'b0;
    rd(8'h02, 32'h0, "cmd_status");
    rd(8'h03, 32'h0, "int_status");
    $display("test reset done");
    for (i = 1; i < 6; i++) begin
      pulse;
      rd(8'h02, {14'h0, i[1:0], 16'h0}, "tally");
    end
    rd(8'h03, 32'h1, "flag");
    host_cpu_model_i.cmd(8'h82, 32'hfffe_fffe, q);
    rd(8'h02, 32'h0001_0000, "reserved");
    host_cpu_model_i.cmd(8'h83, 32'h1, q);
    rd(8'h03, 32'h0, "flag_clear");
    // overrun and clear on one edge: the set wins and the tally still steps
    fork
      pulse;
      host_cpu_model_i.cmd(8'h83, 32'h1, q);
    join
    rd(8'h03, 32'h1, "set_wins");
    rd(8'h02, 32'h0002_0000, "tally_set_wins");
    $display("test overrun done");
    @(posedge mclk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    rd(8'h02, 32'h0, "tally_mid_reset");
    rd(8'h03, 32'h0, "flag_mid_reset");
    $display("test mid reset done");
    pulse;
    core_bus_req = 1'b1;
    t0 = $time;
    host_cpu_model_i.cmd(8'h82, 32'h1, q);
    @(posedge mclk);
    #1 check("suspend", {28'h0, suspend_state, core_reset, host_bus_req, reset_busy}, 32'hd);
    pulse;
    host_cpu_model_i.cmd(8'h82, 32'h0, q);
    rd(8'h02, 32'h1, "busy");
    i = 0;
    while (q[0] === 1'b1 && i < 400) begin
      host_cpu_model_i.cmd(8'h02, 32'h0, q);
      i++;
    end
    check("reset_time", $time - t0 <= 10000, 32'h1);
    rd(8'h02, 32'h0, "after_reset");
    rd(8'h03, 32'h0, "dropped_flag");
    check("bus_req", host_bus_req, 32'h1);
    check("suspend_kept", suspend_state, 32'h1);
    @(posedge mclk);
    #1 suspend_leave = 1'b1;
    @(posedge mclk);
    #1 suspend_leave = 1'b0;
    check("suspend_left", suspend_state, 32'h0);
    $display("test soft reset done");
    results;
  end
endmodule // testbench
